// >>> hdl/bio_top.sv
// Purpose: six-byte i/o port with tri-state control and strobe-paced update
// Assumes: one 20 MHz clock, synchronous reset, pins asynchronous
// Notes:   reset stands in for power-up and self test restore
`timescale 1ns/10ps
`include "bio_regs.svh"

// Contract
// - tri-state command sets selected bytes
// - reset makes every byte high impedance
// - setting holds, unnamed bytes unchanged
// - no selector ignored; missing parameter errors
// - drivers off on software or external
// - tri-state never changes byte direction
// - immediate mode drives on load
// - strobe mode drives on ready strobe
// - newer load replaces pending data
// - every output update pulses data-available
// - readable ready flag; partner asserts readiness
// - immediate input samples on command
// - strobe input latches on data-ready edge
// - reading latched data pulses acknowledge
// - further data-ready ignored until read
// - ready indicators latch on edge
// - acknowledge/available indicators follow line level
// - selecting strobe input asserts acknowledge
// - strobe output asserts available after drive
// - modes reset immediate, hold until changed
// - empty update ignored; unknown letter errors
// - revision query returns VERSION major.minor
// - handshake edges selectable, positive default
// - external level programmable, active low default
module bio_top
(
   input wire logic CLK,
   input wire logic RST,
   input wire logic CE,
   input wire logic [3:0] ADDR,
   input wire logic [15:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [15:0] RDATA,
   input wire logic [47:0] IO_IN,
   output logic [47:0] IO_OUT,
   output logic [47:0] IO_OE,
   input wire logic [5:0] EXT_HIGHZ_LINES,
   input wire logic READY_FOR_DATA_STROBE,
   input wire logic DATA_READY_STROBE,
   output logic DATA_AVAILABLE_STROBE,
   output logic DATA_ACKNOWLEDGE_STROBE
);
   // ------------------------------------------------------------
   // synchronised pins
   // ------------------------------------------------------------
   logic [47:0] in_s;
   logic [5:0] ext_s;
   logic acc_s;
   logic inrdy_s;
   logic acc_p_q;
   logic inrdy_p_q;

   bio_sync #(.W(56)) u_sync
   (
      .CLK(CLK),
      .RST(RST),
      .CE(CE),
      .D({IO_IN, EXT_HIGHZ_LINES, READY_FOR_DATA_STROBE, DATA_READY_STROBE}),
      .Q({in_s, ext_s, acc_s, inrdy_s})
   );

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   logic [5:0] sw_tri_q;
   logic [5:0] lvl_q;
   logic [3:0] edge_q;
   logic [5:0] dir_q;
   bio_pkg::bio_upd_t omode_q;
   bio_pkg::bio_upd_t imode_q;
   logic acc_q;
   logic inrdy_q;
   logic pend_q;
   logic err_tri_q;
   logic err_upd_q;
   logic [3:0] rev_idx_q;
   bio_pkg::bio_byte_t shd_q [6];
   bio_pkg::bio_byte_t out_q [6];
   bio_pkg::bio_byte_t in_q [6];
   logic [15:0] rdata_q;

   logic [5:0] ext_act;
   logic [5:0] eff_tri;
   logic acc_edge;
   logic inrdy_edge;
   logic wr_tri;
   logic wr_upd;
   logic wr_data;
   logic rd_data;
   logic [2:0] didx;
   logic tri_sel;
   logic rd_clear;
   logic release_out;
   logic avail_go;
   logic ack_go;
   logic avail_busy;
   logic ack_busy;

   assign wr_tri = CE && WR && (ADDR == `BIO_A_TRI);
   assign wr_upd = CE && WR && (ADDR == `BIO_A_UPD);
   assign didx = 3'(ADDR - `BIO_A_DATA0);
   assign wr_data = CE && WR && (ADDR >= `BIO_A_DATA0);
   assign rd_data = CE && RD && (ADDR >= `BIO_A_DATA0);
   assign tri_sel = (WDATA[5:0] != 6'h00) || WDATA[`BIO_TRI_ALL];

   // ------------------------------------------------------------
   // handshake edge detection
   // ------------------------------------------------------------
   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         acc_p_q <= 1'b0;
         inrdy_p_q <= 1'b0;
      end
      else if (CE)
      begin
         acc_p_q <= acc_s;
         inrdy_p_q <= inrdy_s;
      end
   end

   // negative edge selection simply swaps the roles of old and new level
   assign acc_edge = edge_q[`BIO_E_ACC] ? (acc_p_q & ~acc_s) : (acc_s & ~acc_p_q);
   assign inrdy_edge = edge_q[`BIO_E_INRDY] ? (inrdy_p_q & ~inrdy_s) : (inrdy_s & ~inrdy_p_q);

   // ------------------------------------------------------------
   // per-byte tri-state and pin drive
   // ------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < 6; gi++)
      begin : g_byte
         assign ext_act[gi] = ~(ext_s[gi] ^ lvl_q[gi]);
         assign eff_tri[gi] = sw_tri_q[gi] | ext_act[gi];
         // direction is a separate register, the tri-state path only masks it
         assign IO_OE[gi*8 +: 8] = {8{dir_q[gi] & ~eff_tri[gi]}};
         assign IO_OUT[gi*8 +: 8] = out_q[gi];

         always_ff @(posedge CLK)
         begin
            if (RST)
               sw_tri_q[gi] <= 1'(`BIO_RST_SWTRI >> gi);
            else if (wr_tri && WDATA[`BIO_TRI_PAR] && (WDATA[gi] || WDATA[`BIO_TRI_ALL]))
               sw_tri_q[gi] <= WDATA[`BIO_TRI_ACT];
         end

         always_ff @(posedge CLK)
         begin
            if (RST)
            begin
               shd_q[gi] <= 8'h00;
               out_q[gi] <= 8'h00;
            end
            else if (CE)
            begin
               if (wr_data && (didx == 3'(gi)))
                  shd_q[gi] <= WDATA[7:0];
               if (wr_data && (didx == 3'(gi)) && (omode_q == bio_pkg::BIO_IMM))
                  out_q[gi] <= WDATA[7:0];
               else if (release_out)
                  out_q[gi] <= shd_q[gi];
            end
         end

         always_ff @(posedge CLK)
         begin
            if (RST)
               in_q[gi] <= 8'h00;
            else if (CE && WR && (ADDR == `BIO_A_INCMD) && (imode_q == bio_pkg::BIO_IMM))
               in_q[gi] <= in_s[gi*8 +: 8];
            else if (CE && (imode_q == bio_pkg::BIO_STRB) && inrdy_edge && (!inrdy_q || rd_clear))
               in_q[gi] <= in_s[gi*8 +: 8];
         end
      end
   endgenerate

   // ------------------------------------------------------------
   // configuration registers
   // ------------------------------------------------------------
   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         lvl_q <= `BIO_RST_LVL;
         edge_q <= `BIO_RST_EDGE;
         dir_q <= `BIO_RST_DIR;
      end
      else if (CE && WR)
      begin
         if (ADDR == `BIO_A_LVL)
            lvl_q <= WDATA[5:0];
         if (ADDR == `BIO_A_EDGE)
            edge_q <= WDATA[3:0];
         if (ADDR == `BIO_A_DIR)
            dir_q <= WDATA[5:0];
      end
   end

   // ------------------------------------------------------------
   // update modes and command errors
   // ------------------------------------------------------------
   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         omode_q <= bio_pkg::BIO_IMM;
         imode_q <= bio_pkg::BIO_IMM;
      end
      else if (wr_upd)
      begin
         unique case (WDATA[7:0])
            `BIO_UPD_L: omode_q <= bio_pkg::BIO_IMM;
            `BIO_UPD_R: omode_q <= bio_pkg::BIO_STRB;
            `BIO_UPD_I: imode_q <= bio_pkg::BIO_IMM;
            `BIO_UPD_D: imode_q <= bio_pkg::BIO_STRB;
            default:
            begin
            end
         endcase
      end
   end

   // error flags are sticky; a new error in the clearing cycle survives
   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         err_tri_q <= 1'b0;
         err_upd_q <= 1'b0;
      end
      else if (CE)
      begin
         if (wr_tri && tri_sel && !WDATA[`BIO_TRI_PAR])
            err_tri_q <= 1'b1;
         else if (WR && (ADDR == `BIO_A_STAT) && WDATA[`BIO_S_ETRI])
            err_tri_q <= 1'b0;
         if (wr_upd && (WDATA[7:0] != `BIO_UPD_NONE) && (WDATA[7:0] != `BIO_UPD_L) &&
             (WDATA[7:0] != `BIO_UPD_R) && (WDATA[7:0] != `BIO_UPD_I) && (WDATA[7:0] != `BIO_UPD_D))
            err_upd_q <= 1'b1;
         else if (WR && (ADDR == `BIO_A_STAT) && WDATA[`BIO_S_EUPD])
            err_upd_q <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // output handshake
   // ------------------------------------------------------------
   // a ready strobe seen earlier releases a later load at once
   assign release_out = (omode_q == bio_pkg::BIO_STRB) && pend_q && acc_q;

   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         acc_q <= `BIO_RST_ACC;
         pend_q <= 1'b0;
      end
      else if (CE)
      begin
         if (acc_edge)
            acc_q <= 1'b1;
         else if (release_out || (wr_data && (omode_q == bio_pkg::BIO_IMM)))
            acc_q <= 1'b0;
         if (wr_data && (omode_q == bio_pkg::BIO_STRB))
            pend_q <= 1'b1;
         else if (release_out)
            pend_q <= 1'b0;
      end
   end

   assign avail_go = release_out || (wr_data && (omode_q == bio_pkg::BIO_IMM));

   bio_pulse u_avail
   (
      .CLK(CLK),
      .RST(RST),
      .CE(CE),
      .GO(avail_go),
      .BUSY(avail_busy)
   );

   assign DATA_AVAILABLE_STROBE = avail_busy ^ edge_q[`BIO_E_AVAIL];

   // ------------------------------------------------------------
   // input handshake
   // ------------------------------------------------------------
   assign rd_clear = rd_data && (imode_q == bio_pkg::BIO_STRB) && inrdy_q;

   always_ff @(posedge CLK)
   begin
      if (RST)
         inrdy_q <= 1'b0;
      else if (CE)
      begin
         if ((imode_q == bio_pkg::BIO_STRB) && inrdy_edge)
            inrdy_q <= 1'b1;
         else if (rd_clear)
            inrdy_q <= 1'b0;
      end
   end

   assign ack_go = rd_clear || (wr_upd && (WDATA[7:0] == `BIO_UPD_D));

   bio_pulse u_ack
   (
      .CLK(CLK),
      .RST(RST),
      .CE(CE),
      .GO(ack_go),
      .BUSY(ack_busy)
   );

   assign DATA_ACKNOWLEDGE_STROBE = ack_busy ^ edge_q[`BIO_E_ACK];

   // ------------------------------------------------------------
   // read path
   // ------------------------------------------------------------
   function automatic logic [7:0] rev_char(input logic [3:0] i);
      logic [7:0] c;
      c = 8'h00;
      unique case (i)
         4'h0: c = 8'h56;
         4'h1: c = 8'h45;
         4'h2: c = 8'h52;
         4'h3: c = 8'h53;
         4'h4: c = 8'h49;
         4'h5: c = 8'h4f;
         4'h6: c = 8'h4e;
         4'h7: c = 8'h20;
         4'h8: c = `BIO_REV_MAJ;
         4'h9: c = 8'h2e;
         4'ha: c = `BIO_REV_MIN;
         default: c = 8'h00;
      endcase
      return c;
   endfunction

   // the revision text is streamed one character per read and wraps
   always_ff @(posedge CLK)
   begin
      if (RST)
         rev_idx_q <= 4'h0;
      else if (CE && WR && (ADDR == `BIO_A_REV))
         rev_idx_q <= 4'h0;
      else if (CE && RD && (ADDR == `BIO_A_REV))
         rev_idx_q <= (rev_idx_q == `BIO_REV_LEN - 4'h1) ? 4'h0 : rev_idx_q + 4'h1;
   end

   always_ff @(posedge CLK)
   begin
      if (RST)
         rdata_q <= 16'h0000;
      else if (CE)
      begin
         rdata_q <= 16'h0000;
         if (RD)
         begin
            if (ADDR >= `BIO_A_DATA0)
               rdata_q <= {8'h00, in_q[didx]};
            else
            begin
               unique case (ADDR)
                  `BIO_A_TRI: rdata_q <= {10'h000, sw_tri_q};
                  `BIO_A_UPD: rdata_q <= {14'h0000, imode_q, omode_q};
                  `BIO_A_LVL: rdata_q <= {10'h000, lvl_q};
                  `BIO_A_EDGE: rdata_q <= {12'h000, edge_q};
                  `BIO_A_STAT: rdata_q <= {8'h00, DATA_ACKNOWLEDGE_STROBE, DATA_AVAILABLE_STROBE,
                                 err_upd_q, err_tri_q, imode_q, omode_q, inrdy_q, acc_q};
                  `BIO_A_TRIST: rdata_q <= {10'h000, eff_tri};
                  `BIO_A_REV: rdata_q <= {8'h00, rev_char(rev_idx_q)};
                  `BIO_A_DIR: rdata_q <= {10'h000, dir_q};
                  default: rdata_q <= 16'h0000;
               endcase
            end
         end
      end
   end

   assign RDATA = rdata_q;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (RST);

   tri_reset_a: assert property ($fell(RST) |-> sw_tri_q == 6'h3f)
      else $error("tri-state not active after reset");
   tri_or_a: assert property (IO_OE[7:0] != 8'h00 |-> !sw_tri_q[0] && !ext_act[0] && dir_q[0])
      else $error("byte 0 driven while tri-stated");
   tri_all_a: assert property (wr_tri && WDATA[`BIO_TRI_ALL] && WDATA[`BIO_TRI_PAR] |=>
                                sw_tri_q == {6{$past(WDATA[`BIO_TRI_ACT])}})
      else $error("wildcard tri-state not applied");
   tri_nosel_a: assert property (wr_tri && !tri_sel |=> $stable(sw_tri_q) && $stable(dir_q))
      else $error("tri-state changed without selector");
   tri_err_a: assert property (wr_tri && tri_sel && !WDATA[`BIO_TRI_PAR] |=> err_tri_q && $stable(sw_tri_q))
      else $error("missing tri-state parameter not flagged");
   out_imm_a: assert property (wr_data && didx == 3'h0 && omode_q == bio_pkg::BIO_IMM |=>
                               IO_OUT[7:0] == $past(WDATA[7:0]) && avail_busy)
      else $error("immediate load not driven");
   out_rel_a: assert property (CE && release_out && !wr_data |=> out_q[0] == $past(shd_q[0]) && !pend_q)
      else $error("pending data not released");
   inrdy_hold_a: assert property (CE && inrdy_q && inrdy_edge && !rd_clear |=> $stable(in_q[0]) && inrdy_q)
      else $error("data-ready not ignored while latched");
   ack_sel_a: assert property (wr_upd && WDATA[7:0] == `BIO_UPD_D |=> ack_busy [*2])
      else $error("acknowledge not asserted on strobe input select");
   upd_err_a: assert property (wr_upd && WDATA[7:0] == 8'h58 |=> err_upd_q && $stable(omode_q))
      else $error("unknown update letter not flagged");

   out_strb_c: cover property (omode_q == bio_pkg::BIO_STRB && release_out);
   in_strb_c: cover property (inrdy_edge && imode_q == bio_pkg::BIO_STRB ##[1:20] rd_clear);
   ext_tri_c: cover property (ext_act != 6'h00 && sw_tri_q == 6'h00);
endmodule

// >>> hdl/bio_regs.svh
// Purpose: register offsets, field positions, reset values and timing counts
// Assumes: 16-bit register port, 20 MHz clock
// Notes:   definitions only
`ifndef BIO_REGS_SVH
`define BIO_REGS_SVH

// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define BIO_A_TRI     4'h0
`define BIO_A_UPD     4'h1
`define BIO_A_LVL     4'h2
`define BIO_A_EDGE    4'h3
`define BIO_A_INCMD   4'h4
`define BIO_A_STAT    4'h5
`define BIO_A_TRIST   4'h6
`define BIO_A_REV     4'h7
`define BIO_A_DIR     4'h8
`define BIO_A_DATA0   4'ha

// ------------------------------------------------------------
// tri-state command fields
// ------------------------------------------------------------
`define BIO_TRI_ALL   6
`define BIO_TRI_PAR   8
`define BIO_TRI_ACT   9

// ------------------------------------------------------------
// update command letters, zero means no parameter
// ------------------------------------------------------------
`define BIO_UPD_NONE  8'h00
`define BIO_UPD_L     8'h4c
`define BIO_UPD_R     8'h52
`define BIO_UPD_I     8'h49
`define BIO_UPD_D     8'h44

// ------------------------------------------------------------
// edge select bits
// ------------------------------------------------------------
`define BIO_E_INRDY   0
`define BIO_E_ACC     1
`define BIO_E_AVAIL   2
`define BIO_E_ACK     3

// ------------------------------------------------------------
// status bits
// ------------------------------------------------------------
`define BIO_S_ACC     0
`define BIO_S_INRDY   1
`define BIO_S_OMODE   2
`define BIO_S_IMODE   3
`define BIO_S_ETRI    4
`define BIO_S_EUPD    5
`define BIO_S_AVAIL   6
`define BIO_S_ACK     7

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define BIO_RST_SWTRI 6'h3f
`define BIO_RST_LVL   6'h00
`define BIO_RST_EDGE  4'h0
`define BIO_RST_DIR   6'h00
`define BIO_RST_ACC   1'b1

// ------------------------------------------------------------
// revision and timing
// ------------------------------------------------------------
`define BIO_REV_MAJ   8'h31
`define BIO_REV_MIN   8'h30
`define BIO_REV_LEN   4'hb
`define BIO_CLK_MHZ   20
`define BIO_STRB_NS   500
`define BIO_STRB_CYC  (((`BIO_STRB_NS * `BIO_CLK_MHZ) + 999) / 1000)

`endif

// >>> hdl/bio_pkg.sv
// Purpose: shared types of the byte i/o port
// Assumes: nothing
// Notes:   constants live in bio_regs.svh
package bio_pkg;
   typedef enum logic [0:0] {BIO_IMM = 1'b0, BIO_STRB = 1'b1} bio_upd_t;
   typedef logic [3:0] bio_addr_t;
   typedef logic [7:0] bio_byte_t;
endpackage

// >>> hdl/bio_sync.sv
// Purpose: two-flop synchroniser for asynchronous inputs
// Assumes: inputs come from pins
// Notes:   only the second stage is visible
`timescale 1ns/10ps
module bio_sync #(parameter int W = 56)
(
   input wire logic CLK,
   input wire logic RST,
   input wire logic CE,
   input wire logic [W-1:0] D,
   output logic [W-1:0] Q
);
   logic [W-1:0] s1_q;

   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         s1_q <= '0;
         Q <= '0;
      end
      else if (CE)
      begin
         s1_q <= D;
         Q <= s1_q;
      end
   end
endmodule

// >>> hdl/bio_pulse.sv
// Purpose: fixed-width strobe generator
// Assumes: go is a one-cycle request
// Notes:   a new request restarts the width
`timescale 1ns/10ps
`include "bio_regs.svh"
module bio_pulse
(
   input wire logic CLK,
   input wire logic RST,
   input wire logic CE,
   input wire logic GO,
   output logic BUSY
);
   logic [7:0] cnt_q;

   // ------------------------------------------------------------
   // width counter
   // ------------------------------------------------------------
   always_ff @(posedge CLK)
   begin
      if (RST)
         cnt_q <= 8'h00;
      else if (CE)
      begin
         if (GO)
            cnt_q <= 8'(`BIO_STRB_CYC);
         else if (cnt_q != 8'h00)
            cnt_q <= cnt_q - 8'h01;
      end
   end

   assign BUSY = (cnt_q != 8'h00);
endmodule

// >>> verif/bio_partner.sv
// Purpose: far-side parallel device for the byte i/o port
// Assumes: positive edge handshakes, one shared clock
// Notes:   strobes idle low and stand still between handshakes
`timescale 1ns/10ps
module bio_partner
(
   input wire logic CLK,
   input wire logic AUTO,
   input wire logic KICK,
   input wire logic SEND,
   input wire logic [47:0] SEND_DATA,
   input wire logic AVAIL,
   input wire logic [47:0] IO_OUT,
   output logic ACCEPT,
   output logic INRDY,
   output logic [47:0] IO_IN,
   output logic [47:0] GOT
);
   logic avail_q = 1'b0;
   logic [2:0] acc_q = 3'h0;
   logic [2:0] inrdy_q = 3'h0;
   logic [47:0] io_q = 48'h0;
   logic [47:0] got_q = 48'h0;

   assign ACCEPT = (acc_q != 3'h0);
   assign INRDY = (inrdy_q != 3'h0);
   assign IO_IN = io_q;
   assign GOT = got_q;

   // take new data on the rising data-available strobe
   always_ff @(posedge CLK)
   begin
      avail_q <= AVAIL;
      if (AVAIL && !avail_q)
         got_q <= IO_OUT;
   end

   // readiness answered after data taken, or on command when auto is off
   always_ff @(posedge CLK)
   begin
      if (acc_q != 3'h0)
         acc_q <= acc_q + 3'h1;
      else if (KICK || (AUTO && AVAIL && !avail_q))
         acc_q <= 3'h1;
   end

   // new input data presented together with a data-ready pulse
   always_ff @(posedge CLK)
   begin
      if (inrdy_q != 3'h0)
         inrdy_q <= inrdy_q + 3'h1;
      else if (SEND)
      begin
         io_q <= SEND_DATA;
         inrdy_q <= 3'h1;
      end
   end
endmodule

// >>> verif/bio_top_bench.sv
// Purpose: self-checking bench for the byte i/o port
// Assumes: 20 MHz clock, partner model on the handshake side
// Notes:   table rows first, then handshake cases
`timescale 1ns/10ps
module bio_top_bench;
   logic clk, rst, wr_en, rd_en, send, kick, auto_acc;
   logic acc, inrdy, avail, ack;
   logic [3:0] addr;
   logic [5:0] ext;
   logic [15:0] wdata, rdata, v;
   logic [47:0] io_in, io_out, io_oe, send_data, got;
   int failures = 0;
   int n_checks = 0;
   string rev_text = "VERSION 1.0";
   // reset rows: {addr, value}
   logic [19:0] rs [7] = '{20'h0003f, 20'h10000, 20'h20000, 20'h30000, 20'h50001, 20'h6003f, 20'h80000};
   // rows: {addr, write data, read back}
   logic [35:0] rows [16] = '{36'h8003f003f, 36'h00000003f, 36'h0010e0031, 36'h003330033,
      36'h000040033, 36'h001400000, 36'h100520001, 36'h100000001, 36'h100440003, 36'h1004c0002,
      36'h100490000, 36'h100580000, 36'h200150015, 36'h200000000, 36'h3000a000a, 36'h300000000};

   bio_top dut (.CLK(clk), .RST(rst), .CE(1'b1), .ADDR(addr), .WDATA(wdata), .WR(wr_en), .RD(rd_en),
      .RDATA(rdata), .IO_IN(io_in), .IO_OUT(io_out), .IO_OE(io_oe), .EXT_HIGHZ_LINES(ext),
      .READY_FOR_DATA_STROBE(acc), .DATA_READY_STROBE(inrdy), .DATA_AVAILABLE_STROBE(avail),
      .DATA_ACKNOWLEDGE_STROBE(ack));

   bio_partner far (.CLK(clk), .AUTO(auto_acc), .KICK(kick), .SEND(send), .SEND_DATA(send_data),
      .AVAIL(avail), .IO_OUT(io_out), .ACCEPT(acc), .INRDY(inrdy), .IO_IN(io_in), .GOT(got));

   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // ------------------------------------------------------------
   // bus and check tasks
   // ------------------------------------------------------------
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
      #1;
   endtask

   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      #1;
      d = rdata;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic pulse_send(input logic [47:0] d);
      @(posedge clk);
      send <= 1'b1;
      send_data <= d;
      @(posedge clk);
      send <= 1'b0;
      cyc(6);
   endtask

   task automatic chk(input string n, input logic [47:0] s, input logic [47:0] e);
      n_checks++;
      if (s !== e)
      begin
         failures++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask

   task automatic final_report();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // ------------------------------------------------------------
   // watchdog, well past the few hundred cycles the tests need
   // ------------------------------------------------------------
   initial
   begin
      #200000;
      failures++;
      final_report();
   end

   initial
   begin
      rst = 1'b1;
      {wr_en, rd_en, send, kick} = 4'h0;
      auto_acc = 1'b1;
      addr = 4'h0;
      wdata = 16'h0000;
      send_data = 48'h0;
      ext = 6'h3f;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      foreach (rs[i])
      begin
         rd(rs[i][19:16], v);
         chk("reset value", v, rs[i][15:0]);
      end
      chk("reset oe", io_oe, 48'h0);
      $display("test reset done");
      foreach (rows[i])
      begin
         wr(rows[i][35:32], rows[i][31:16]);
         rd(rows[i][35:32], v);
         chk("row", v, rows[i][15:0]);
      end
      rd(4'h8, v);
      chk("direction", v, 16'h003f);
      rd(4'h5, v);
      chk("errors", v, 16'h0031);
      wr(4'h5, 16'h0030);
      rd(4'h5, v);
      chk("errors cleared", v, 16'h0001);
      $display("test table done");
      chk("oe all", io_oe, 48'hffffffffffff);
      @(posedge clk);
      ext <= 6'h3b;
      cyc(5);
      chk("oe ext", io_oe, 48'hffffff00ffff);
      rd(4'h6, v);
      chk("eff tri", v, 16'h0004);
      @(posedge clk);
      ext <= 6'h3f;
      wr(4'ha, 16'h005a);
      chk("imm out", io_out[7:0], 8'h5a);
      cyc(1);
      chk("avail imm", avail, 1'b1);
      rd(4'h5, v);
      chk("flag low", v[0], 1'b0);
      cyc(12);
      rd(4'h5, v);
      chk("flag back", v[0], 1'b1);
      $display("test immediate out done");
      auto_acc <= 1'b0;
      wr(4'h1, 16'h0052);
      wr(4'ha, 16'h0011);
      cyc(3);
      chk("ready out", io_out[7:0], 8'h11);
      wr(4'ha, 16'h0022);
      wr(4'ha, 16'h0033);
      cyc(4);
      chk("held out", io_out[7:0], 8'h11);
      @(posedge clk);
      kick <= 1'b1;
      @(posedge clk);
      kick <= 1'b0;
      cyc(10);
      chk("latest out", io_out[7:0], 8'h33);
      chk("far got", got[7:0], 8'h33);
      $display("test strobe out done");
      wr(4'h1, 16'h0044);
      cyc(1);
      chk("ack on mode", ack, 1'b1);
      cyc(10);
      pulse_send(48'h665544332211);
      rd(4'h5, v);
      chk("in flag", v[1], 1'b1);
      pulse_send(48'hffffffffffff);
      rd(4'ha, v);
      chk("latched in", v, 16'h0011);
      chk("ack on read", ack, 1'b1);
      rd(4'h5, v);
      chk("in cleared", v[1], 1'b0);
      wr(4'h1, 16'h0049);
      wr(4'h4, 16'h0000);
      rd(4'hb, v);
      chk("imm in", v, 16'h00ff);
      $display("test input done");
      wr(4'h7, 16'h0000);
      for (int i = 0; i < 11; i++)
      begin
         rd(4'h7, v);
         chk("revision", v, {8'h00, rev_text[i]});
      end
      $display("test revision done");
      // mid-run reset: output mode is strobe-paced and all bytes driven before it
      @(posedge clk);
      rst <= 1'b1;
      @(posedge clk);
      rst <= 1'b0;
      rd(4'h0, v);
      chk("reset tri", v, 16'h003f);
      rd(4'h1, v);
      chk("reset modes", v, 16'h0000);
      rd(4'h5, v);
      chk("reset status", v, 16'h0001);
      $display("test mid reset done");
      final_report();
   end
endmodule
